// ---- verilog/csmp_device.sv ----
module csmp_device #(
  parameter int SAMPLE_DIV = csmp_pkg::SAMPLE_DIV,
  parameter int SCLK_DIV = csmp_pkg::SCLK_DIV
) (
  input wire logic clock,
  input wire logic rst_n,
  csmp_link_if.dev link,
  input wire logic [15:0] adcSample,
  output logic [15:0] dacWord,
  output logic dacUpdate,
  output logic mixedMode,
  output logic dataMode,
  output logic [3:0] powerBits,
  output logic adcValid
);
  // refuse dividers the counters cannot serve; a sample period must hold
  // a whole number of bit periods or some sample events miss the bit pulse
  if (SAMPLE_DIV < 64 || SAMPLE_DIV > 65536 || SCLK_DIV < 2 ||
      SCLK_DIV > 256 || SAMPLE_DIV % SCLK_DIV != 0) begin : g_bad_div
    $error("csmp_device: unsupported divider setting");
  end

  typedef enum logic [1:0] {
    CSMP_IDLE = 2'b00,
    CSMP_SEND = 2'b01
  } csmp_tx_t;

  logic [15:0] sampCnt_q;
  logic [7:0] sclkCnt_q;
  logic bitEn;
  logic [7:0] regs_q [csmp_pkg::NUM_REGS];
  csmp_tx_t txState_q;
  logic [15:0] txSh_q;
  logic [4:0] txCnt_q;
  logic fsOut_q;
  logic pendLoad_q;
  logic [15:0] pendWord_q;
  logic [15:0] rxSh_q;
  logic [4:0] rxCnt_q;
  logic rxDone;
  logic [15:0] rxWord;
  logic isCtrl;
  logic [2:0] addrF;
  logic [2:0] regSel;
  logic [15:0] rbWord;
  logic sampleEv;

  // bit clock enable from the divided master clock
  // reset to the terminal count so the first bit pulse and the first
  // sample event fall on the first edge after reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclkCnt_q <= 8'(SCLK_DIV - 1);
    end else if (sclkCnt_q == 8'(SCLK_DIV - 1)) begin
      sclkCnt_q <= 8'h00;
    end else begin
      sclkCnt_q <= sclkCnt_q + 8'h01;
    end
  end
  assign bitEn = rst_n && (sclkCnt_q == 8'(SCLK_DIV - 1));

  // sample counter counts master clocks: rate = divided_master_clock/SAMPLE_DIV
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sampCnt_q <= 16'(SAMPLE_DIV - 1);
    end else if (sampCnt_q == 16'(SAMPLE_DIV - 1)) begin
      sampCnt_q <= 16'h0000;
    end else begin
      sampCnt_q <= sampCnt_q + 16'h0001;
    end
  end
  assign sampleEv = (sampCnt_q == 16'(SAMPLE_DIV - 1)) && bitEn;

  // receive shifter; the host sync starts a word
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxSh_q <= 16'h0000;
      rxCnt_q <= 5'h00;
    end else if (bitEn) begin
      if (link.hostTxFrameSync) begin
        rxSh_q <= {rxSh_q[14:0], link.hostData};
        rxCnt_q <= 5'h0F;
      end else if (rxCnt_q != 5'h00) begin
        rxSh_q <= {rxSh_q[14:0], link.hostData};
        rxCnt_q <= rxCnt_q - 5'h01;
      end
    end
  end
  assign rxDone = bitEn && (rxCnt_q == 5'h01);
  assign rxWord = {rxSh_q[14:0], link.hostData};
  assign addrF = rxWord[csmp_pkg::ADDR_HI:csmp_pkg::ADDR_LO];
  assign regSel = rxWord[csmp_pkg::REG_HI:csmp_pkg::REG_LO];
  // mixed mode: the MSB decides; program mode: all control; data: all dac
  assign isCtrl = mixedMode ? rxWord[csmp_pkg::MSB_BIT]
                            : !dataMode;

  // control register writes from addressed words
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < csmp_pkg::NUM_REGS; i++) begin
        regs_q[i] <= csmp_pkg::REG_RESET;
      end
    end else if (rxDone && isCtrl && addrF == 3'h0 &&
                 !rxWord[csmp_pkg::READBACK_BIT]) begin
      regs_q[regSel] <= rxWord[csmp_pkg::DATA_W-1:0];
    end
  end

  // mode and power views; power bits follow register C in every mode
  assign mixedMode = regs_q[csmp_pkg::REG_A][csmp_pkg::MM_BIT] &&
                     regs_q[csmp_pkg::REG_A][csmp_pkg::PDS_BIT];
  assign dataMode = regs_q[csmp_pkg::REG_A][csmp_pkg::PDS_BIT];
  assign powerBits = regs_q[csmp_pkg::REG_C][3:0];
  assign adcValid = regs_q[csmp_pkg::REG_C][csmp_pkg::ADC_PWR_BIT];

  // dac register: only data words in data or mixed mode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dacWord <= 16'h0000;
      dacUpdate <= 1'b0;
    end else begin
      dacUpdate <= 1'b0;
      if (rxDone && !isCtrl) begin
        dacWord <= rxWord;
        dacUpdate <= 1'b1;
      end
    end
  end

  // readback word with address already decremented
  assign rbWord = {1'b1, 1'b1, addrF - 3'h1, regSel, regs_q[regSel]};

  // pending output: readback or pass-on of a foreign word
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pendLoad_q <= 1'b0;
      pendWord_q <= 16'h0000;
    end else if (rxDone && isCtrl && rxWord[csmp_pkg::READBACK_BIT] &&
                 addrF == 3'h0) begin
      pendLoad_q <= 1'b1;
      pendWord_q <= rbWord;
    end else if (rxDone && isCtrl && addrF != 3'h0) begin
      pendLoad_q <= 1'b1;
      pendWord_q <= {rxWord[15:14], addrF - 3'h1, rxWord[10:0]};
    end else if (txState_q == CSMP_IDLE && bitEn && !sampleEv) begin
      pendLoad_q <= 1'b0;
    end
  end

  // transmit: sample event or pending word starts a frame
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      txState_q <= CSMP_IDLE;
      txSh_q <= 16'h0000;
      txCnt_q <= 5'h00;
      fsOut_q <= 1'b0;
    end else if (bitEn) begin
      case (txState_q)
        CSMP_IDLE: begin
          if (sampleEv || pendLoad_q) begin
            fsOut_q <= 1'b1;
            txState_q <= CSMP_SEND;
            txCnt_q <= 5'h10;
            // the sample keeps its slot; a pending word waits one frame
            if (!sampleEv) begin
              txSh_q <= pendWord_q;
            end else if (adcValid) begin
              txSh_q <= adcSample;
            end else begin
              txSh_q <= csmp_pkg::INVALID_ADC;
            end
          end
        end
        CSMP_SEND: begin
          fsOut_q <= 1'b0;
          if (txCnt_q == 5'h01) begin
            txState_q <= CSMP_IDLE;
          end
          txCnt_q <= txCnt_q - 5'h01;
          if (!fsOut_q) begin
            txSh_q <= {txSh_q[14:0], 1'b0};
          end
        end
        default: txState_q <= CSMP_IDLE;
      endcase
    end
  end

  assign link.bitClk = bitEn;
  assign link.outFrameSync = fsOut_q;
  assign link.devData = txSh_q[csmp_pkg::MSB_BIT];
endmodule

// ---- verilog/csmp_pkg.sv ----
package csmp_pkg;
  localparam int WORD_W = 16;
  localparam int MSB_BIT = 15;         // control/data discriminator
  localparam int READBACK_BIT = 14;
  localparam int ADDR_HI = 13;
  localparam int ADDR_LO = 11;
  localparam int REG_HI = 10;          // register select field
  localparam int REG_LO = 8;
  localparam int DATA_W = 8;
  localparam logic [2:0] REG_A = 3'h0;
  localparam logic [2:0] REG_B = 3'h1;
  localparam logic [2:0] REG_C = 3'h2;
  localparam int NUM_REGS = 8;
  localparam int MM_BIT = 0;           // mixed_mode_bit in register A
  localparam int PDS_BIT = 1;          // program_data_select in register A
  localparam int ADC_PWR_BIT = 0;      // register C power bits
  localparam int DAC_PWR_BIT = 1;
  localparam int REF_PWR_BIT = 2;
  localparam int BUFFERED_REFERENCE_OUTPUT_PWR_BIT = 3;
  localparam int SAMPLE_DIV = 256;     // sampling rate = divided_master_clock/256
  localparam int SCLK_DIV = 2;         // bit clock = divided_master_clock/2
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] INVALID_ADC = 16'h0000;
  // apb register offsets of the controller
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TXW = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_RXW = 8'h0C;
endpackage

// ---- verilog/csmp_link_if.sv ----
interface csmp_link_if;
  logic bitClk;        // bit-rate enable pulse from the device
  logic outFrameSync;  // device output frame sync
  logic devData;       // device serial out
  logic hostTxFrameSync; // host frame sync, feeds in_frame_sync
  logic hostData;
  modport dev (output bitClk, output outFrameSync, output devData,
               input hostTxFrameSync, input hostData);
  modport host (input bitClk, input outFrameSync, input devData,
                output hostTxFrameSync, output hostData);
endinterface

// ---- verilog/csmp_host.sv ----
module csmp_host (
  input wire logic clock,
  input wire logic rst_n,
  csmp_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [1:0] {
    CSMP_H_IDLE = 2'b00,
    CSMP_H_SEND = 2'b01
  } csmp_htx_t;

  csmp_htx_t st_q;
  logic [15:0] txWord_q;
  logic txPend_q;
  logic loopback_q;
  logic [15:0] sh_q;
  logic [4:0] cnt_q;
  logic fs_q;
  logic [15:0] rxSh_q;
  logic [4:0] rxCnt_q;
  logic [15:0] rxWord_q;
  logic rxNew_q;
  logic gotOut_q;
  logic wr;
  logic rd;
  logic rxDone;
  logic txGo;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite; // setup phase of a read
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel && penable && paddr != csmp_pkg::OFS_CTRL &&
                   paddr != csmp_pkg::OFS_TXW &&
                   paddr != csmp_pkg::OFS_STAT &&
                   paddr != csmp_pkg::OFS_RXW;

  // receive the device word on its frame sync
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxSh_q <= 16'h0000;
      rxCnt_q <= 5'h00;
    end else if (link.bitClk) begin
      if (link.outFrameSync) begin
        rxCnt_q <= 5'h10;
      end else if (rxCnt_q != 5'h00) begin
        rxSh_q <= {rxSh_q[14:0], link.devData};
        rxCnt_q <= rxCnt_q - 5'h01;
      end
    end
  end
  assign rxDone = link.bitClk && rxCnt_q == 5'h01 && !link.outFrameSync;

  // received word latch; new-data set wins over read clear; the clear
  // sits on the edge that latches read data so no word slips between
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxWord_q <= 16'h0000;
      rxNew_q <= 1'b0;
    end else if (rxDone) begin
      rxWord_q <= {rxSh_q[14:0], link.devData};
      rxNew_q <= 1'b1;
    end else if (rd && paddr == csmp_pkg::OFS_RXW) begin
      rxNew_q <= 1'b0;
    end
  end

  // gate: send only after the device word arrived
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gotOut_q <= 1'b0;
    end else if (rxDone) begin
      gotOut_q <= 1'b1;
    end else if (link.bitClk && link.outFrameSync) begin
      gotOut_q <= 1'b0; // a new device word is under way
    end else if (st_q == CSMP_H_SEND && loopback_q) begin
      gotOut_q <= 1'b0; // one word per period
    end
  end

  // start a word only between device words
  assign txGo = link.bitClk && st_q == CSMP_H_IDLE && txPend_q &&
                gotOut_q && !link.outFrameSync;

  // apb registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      txWord_q <= 16'h0000;
      txPend_q <= 1'b0;
      loopback_q <= 1'b0;
    end else begin
      if (wr && paddr == csmp_pkg::OFS_TXW) begin
        txWord_q <= pwdata[15:0];
        txPend_q <= 1'b1;
      end else if (txGo) begin
        txPend_q <= 1'b0;
      end
      if (wr && paddr == csmp_pkg::OFS_CTRL) begin
        loopback_q <= pwdata[0];
      end
    end
  end

  // read data mux
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (rd) begin
      case (paddr)
        csmp_pkg::OFS_CTRL: prdata <= {31'h0, loopback_q};
        csmp_pkg::OFS_TXW: prdata <= {16'h0000, txWord_q};
        csmp_pkg::OFS_STAT: prdata <= {29'h0, gotOut_q, rxNew_q, txPend_q};
        csmp_pkg::OFS_RXW: prdata <= {16'h0000, rxWord_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // transmit; back-to-back words have no gap
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= CSMP_H_IDLE;
      sh_q <= 16'h0000;
      cnt_q <= 5'h00;
      fs_q <= 1'b0;
    end else if (link.bitClk) begin
      case (st_q)
        CSMP_H_IDLE: begin
          fs_q <= 1'b0;
          if (txGo) begin
            st_q <= CSMP_H_SEND;
            sh_q <= txWord_q;
            fs_q <= 1'b1;
            cnt_q <= 5'h0F;
          end
        end
        CSMP_H_SEND: begin
          fs_q <= 1'b0;
          sh_q <= {sh_q[14:0], 1'b0};
          cnt_q <= cnt_q - 5'h01;
          if (cnt_q == 5'h01) begin
            st_q <= CSMP_H_IDLE;
          end
        end
        default: st_q <= CSMP_H_IDLE;
      endcase
    end
  end

  assign link.hostTxFrameSync = fs_q;
  assign link.hostData = sh_q[csmp_pkg::MSB_BIT];
endmodule

// ---- tb/csmp_link_properties.sv ----
module csmp_link_properties #(
  parameter int SCLK_DIV = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bitClk,
  input wire logic outFrameSync,
  input wire logic devData,
  input wire logic hostTxFrameSync,
  input wire logic hostData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] devCnt_q;
  logic [4:0] hostCnt_q;
  logic [15:0] devSh_q;
  logic [7:0] gap_q;
  logic seen_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // bits still due in each direction, reloaded at every frame sync
  always_ff @(posedge clock) begin
    if (!rst_n)
      devCnt_q <= 5'h00;
    else if (bitClk && outFrameSync)
      devCnt_q <= 5'h10;
    else if (bitClk && devCnt_q != 5'h00)
      devCnt_q <= devCnt_q - 5'h01;
  end
  always_ff @(posedge clock) begin
    if (!rst_n)
      hostCnt_q <= 5'h00;
    else if (bitClk && hostTxFrameSync)
      hostCnt_q <= 5'h0F; // first bit rides with the sync
    else if (bitClk && hostCnt_q != 5'h00)
      hostCnt_q <= hostCnt_q - 5'h01;
  end
  // device word so far, first bit ends on top
  always_ff @(posedge clock) begin
    if (bitClk && devCnt_q != 5'h00)
      devSh_q <= {devSh_q[14:0], devData};
  end
  // clocks between bit pulses; the first gap after reset is not judged
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gap_q <= 8'h00;
      seen_q <= 1'b0;
    end else if (bitClk) begin
      gap_q <= 8'h00;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 8'h01;
    end
  end
  a_dev_bit_aligned: assert property (!$past(bitClk) |->
    $stable(outFrameSync) && $stable(devData))
    else $error("device line moved between bit pulses");
  a_host_bit_aligned: assert property (!$past(bitClk) |->
    $stable(hostTxFrameSync) && $stable(hostData))
    else $error("host line moved between bit pulses");
  a_bit_period: assert property (bitClk && seen_q |->
    gap_q == 8'(SCLK_DIV - 1))
    else $error("bit pulse spacing wrong");
  a_dev_sync_one: assert property (bitClk && outFrameSync |=>
    !outFrameSync)
    else $error("device sync longer than one bit");
  a_dev_word_len: assert property (bitClk && outFrameSync |->
    devCnt_q <= 5'h01)
    else $error("device sync inside a word");
  a_host_sync_one: assert property (bitClk && hostTxFrameSync |=>
    !hostTxFrameSync)
    else $error("host sync longer than one bit");
  a_host_word_len: assert property (bitClk && hostTxFrameSync |->
    hostCnt_q == 5'h00)
    else $error("host sync inside a word");
  a_host_after_dev: assert property (bitClk && hostTxFrameSync |->
    devCnt_q == 5'h00)
    else $error("host sent while device word in flight");
  a_readback_addr: assert property (bitClk && devCnt_q == 5'h01 &&
    devSh_q[14:13] == 2'b11 |-> devSh_q[12:10] == 3'b111)
    else $error("readback address not 111");
endmodule

// ---- tb/codec_serial_mixed_mode_port_tb.sv ----
module codec_serial_mixed_mode_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, errS, dacUpdate, mixedMode, dataMode, adcValid;
  logic [15:0] adcSample = 16'h0000;
  logic [15:0] dacWord, w;
  logic [3:0] powerBits;
  logic [15:0] dacQ[$];
  int errors = 0;
  int n_compared = 0;
  int seed = 32'h28CF;
  int n;
  csmp_link_if link();
  always #10 clock = ~clock;
  csmp_device #(.SAMPLE_DIV(128), .SCLK_DIV(2)) u_csmp_device (
    .clock(clock), .rst_n(rst_n), .link(link), .adcSample(adcSample),
    .dacWord(dacWord), .dacUpdate(dacUpdate), .mixedMode(mixedMode),
    .dataMode(dataMode), .powerBits(powerBits), .adcValid(adcValid));
  csmp_host u_csmp_host (.clock(clock), .rst_n(rst_n), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  csmp_link_properties #(.SCLK_DIV(2)) u_csmp_link_properties (
    .clock(clock), .rst_n(rst_n), .bitClk(link.bitClk),
    .outFrameSync(link.outFrameSync), .devData(link.devData),
    .hostTxFrameSync(link.hostTxFrameSync), .hostData(link.hostData));
  task automatic report_and_stop();
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic tmo(string nm);
    errors++;
    $display("[ERR] %s exp done got timeout", nm);
    report_and_stop();
  endtask
  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 40);
    if (pready !== 1'b1)
      tmo("pready");
    rd = prdata;
    errS = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic waitst(int b, logic v);
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, csmp_pkg::OFS_STAT, 32'h0);
      if (rd[b] === v)
        return;
    end
    tmo("status");
  endtask
  task automatic nextrx();
    waitst(1, 1'b1);
    apb(1'b0, csmp_pkg::OFS_RXW, 32'h0);
  endtask
  // queue a word once the previous one has left
  task automatic sendw(logic [15:0] x);
    waitst(0, 1'b0);
    apb(1'b1, csmp_pkg::OFS_TXW, {16'h0000, x});
  endtask
  // skip unrelated samples until a word matching the mask shows up
  task automatic findrx(logic [15:0] m, logic [15:0] e);
    for (int i = 0; i < 8; i++) begin
      nextrx();
      if ((rd[15:0] & m) === (e & m))
        break;
    end
    chk("rxWord", {16'h0000, e}, rd);
  endtask
  // dac updates are matched against data words in the order sent
  always @(negedge clock) begin
    if (dacUpdate === 1'b1) begin
      if (dacQ.size() == 0)
        chk("dacUpdate", 0, 1);
      else
        chk("dacWord", 32'(dacQ.pop_front()), 32'(dacWord));
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    adcSample <= 16'($random(seed)) & 16'h3FFF;
    @(posedge clock);
    nextrx();
    chk("firstWord", 32'(csmp_pkg::INVALID_ADC), rd);
    chk("adcValid", 0, 32'(adcValid));
    apb(1'b0, 8'h10, 32'h0);
    chk("pslverr", 1, 32'(errS));
    sendw(16'h8003);
    waitst(0, 1'b0);
    nextrx();
    nextrx();
    chk("mixedMode", 1, 32'(mixedMode));
    chk("powerBits", 0, 32'(powerBits));
    sendw(16'h810B);
    sendw(16'h820F);
    waitst(0, 1'b0);
    nextrx();
    nextrx();
    chk("powerBits", 32'hF, 32'(powerBits));
    chk("adcValid", 1, 32'(adcValid));
    nextrx();
    chk("adcWord", 32'(adcSample), rd);
    for (n = 0; n < 4; n++) begin
      w = 16'($random(seed)) & 16'h7FFF;
      dacQ.push_back(w);
      if (n == 3)
        sendw(16'h820F);
      sendw(w);
    end
    sendw(16'hC200);
    findrx(16'hC000, 16'hFA0F);
    sendw(16'h8905);
    findrx(16'h8000, 16'h8105);
    chk("powerBits", 32'hF, 32'(powerBits));
    apb(1'b1, csmp_pkg::OFS_CTRL, 32'h00000001);
    apb(1'b0, csmp_pkg::OFS_CTRL, 32'h0);
    chk("loopback", 1, rd);
    w = 16'($random(seed)) & 16'h7FFF;
    dacQ.push_back(w);
    sendw(w);
    waitst(0, 1'b0);
    apb(1'b0, csmp_pkg::OFS_STAT, 32'h0);
    chk("gotOut", 0, 32'(rd[2]));
    for (n = 0; n < 400 && dacQ.size() != 0; n++)
      @(posedge clock);
    if (dacQ.size() != 0)
      tmo("dacQueue");
    report_and_stop();
  end
endmodule
